// ---- rtl/sai_pkg.sv ----
package sai_pkg;
  // register map, byte addresses on the bus
  localparam int unsigned ADDR_W        = 6;
  localparam logic [5:0]  ADDR_CTRL     = 6'h00;
  localparam logic [5:0]  ADDR_STATUS   = 6'h04;
  localparam logic [5:0]  ADDR_CHAN0    = 6'h08;
  localparam logic [5:0]  ADDR_CHAN_END = 6'h24;
  // serial_input_control fields
  localparam int unsigned CTRL_W        = 8;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam int unsigned CTRL_FMT_LSB  = 0;
  localparam int unsigned CTRL_FMT_W    = 3;
  localparam int unsigned CTRL_BCP_BIT  = 3;
  localparam int unsigned CTRL_WCP_BIT  = 4;
  localparam logic [7:0]  CTRL_WMASK    = 8'h1F;
  // format codes
  localparam logic [2:0]  FMT_I2S       = 3'h0;
  localparam logic [2:0]  FMT_LEFT      = 3'h1;
  localparam logic [2:0]  FMT_TDM       = 3'h2;
  localparam logic [2:0]  FMT_RIGHT     = 3'h3;
  // status fields
  localparam int unsigned STATUS_RSVD_BIT = 0;
  localparam int unsigned STATUS_SYNC_BIT = 1;
  localparam int unsigned STATUS_CNT_LSB  = 16;
  localparam int unsigned FRAME_CNT_W     = 16;
  // framing
  localparam int unsigned SAMPLE_W      = 24;
  localparam int unsigned NUM_CH        = 8;
  localparam int unsigned NUM_PINS      = 4;
  localparam int unsigned BIT_CNT_W     = 8;
  localparam int unsigned SLOT_LSB      = 5;
  localparam logic [7:0]  I2S_LAST_BIT  = 8'h18;
  localparam logic [7:0]  LEFT_LAST_BIT = 8'h17;
  localparam logic [4:0]  TDM_LAST_BIT  = 5'h18;
  localparam logic [2:0]  TDM_LAST_SLOT = 3'h7;
  localparam logic [7:0]  TDM_HALF_BIT  = 8'h80;
  localparam logic [2:0]  TDM_HALF_SLOT = 3'h4;

  typedef logic [SAMPLE_W-1:0] sample_t;

  function automatic logic fmt_reserved(input logic [2:0] fmt);
    return fmt > FMT_RIGHT;
  endfunction
endpackage

// ---- rtl/frame_if.sv ----
`timescale 1ns/100ps
interface frame_if;
  sai_pkg::sample_t [sai_pkg::NUM_CH-1:0] bank;
  logic                                   toggle;
  modport src (output bank, output toggle);
  modport dst (input bank, input toggle);
endinterface

// ---- rtl/bit_sync.sv ----
`timescale 1ns/100ps
module bit_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s st;
  sync_s next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule // bit_sync

// ---- rtl/frame_collect.sv ----
`timescale 1ns/100ps
module frame_collect (
  // clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  // frame handed over from the link side
  frame_if.dst                                        link,
  // copy of the last whole frame
  output sai_pkg::sample_t [sai_pkg::NUM_CH-1:0]      bank,
  output logic                                        frame_pulse
);
  typedef struct packed {
    logic                                   s1;
    logic                                   s2;
    logic                                   s3;
    logic                                   pulse;
    sai_pkg::sample_t [sai_pkg::NUM_CH-1:0] bank;
  } coll_s;

  coll_s st;
  coll_s next_st;

  // the link holds its bank still for a whole frame after each toggle
  always_comb begin
    next_st       = st;
    next_st.s1    = link.toggle;
    next_st.s2    = st.s1;
    next_st.s3    = st.s2;
    next_st.pulse = st.s2 ^ st.s3;
    if (st.s2 ^ st.s3) begin
      next_st.bank = link.bank;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bank        = st.bank;
  assign frame_pulse = st.pulse;
endmodule // frame_collect

// ---- rtl/serial_audio_rx.sv ----
// Function
// (R1) polarity 0 stereo: word clock low is left, high is right
// (R2) polarity 1 stereo: channel assignment swapped, high is left
// (R3) TDM, polarity 0: frame starts at bit edge after word clock falls
// (R4) TDM, polarity 1: frame starts at bit edge after word clock rises
// (R5) pulse word clock: first pulse edge starts frame; low pulse for 0, high for 1
// (R6) bit clock polarity 0: data changes falling, sampled rising; 1 reversed
// (R7) polarity bits override format field; software writes all five together
// (R8) left/right-justified: word clock high for left, needs polarity set to 1
// (R9) source puts the whole TDM stream on the first data input only
// (R10) TDM slot MSB arrives one bit clock after slot start, captured there
// (R11) TDM channels 0-3 in first half of frame, 4-7 in second half
// (R12) auxiliary codec: rising frame start, falling data change, MSB delayed one
// (R13) three-bit format field selects I2S, left, TDM, right; others reserved
`timescale 1ns/100ps
module serial_audio_rx (
  // system clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // register bus
  input  wire logic [sai_pkg::ADDR_W-1:0]    address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [31:0]                   writedata,
  input  wire logic [3:0]                    byteenable,
  output logic      [31:0]                   readdata,
  output logic                               waitrequest,
  // serial audio link
  input  wire logic                          bit_clock,
  input  wire logic                          word_clock,
  input  wire logic [sai_pkg::NUM_PINS-1:0]  serial_data_inputs
);
  typedef struct packed {
    logic [sai_pkg::CTRL_W-1:0]      ctrl;
    logic                            waitrequest;
    logic [31:0]                     readdata;
    logic [sai_pkg::FRAME_CNT_W-1:0] frame_cnt;
    logic                            synced;
  } bus_s;

  typedef struct packed {
    logic                                     lr_prev;
    logic                                     framed;
    logic [sai_pkg::BIT_CNT_W-1:0]            bit_cnt;
    sai_pkg::sample_t [sai_pkg::NUM_PINS-1:0] shreg;
    sai_pkg::sample_t [sai_pkg::NUM_CH-1:0]   bank;
    sai_pkg::sample_t [sai_pkg::NUM_CH-1:0]   hold;
    logic                                     toggle;
  } link_s;

  bus_s                                     bq;
  bus_s                                     next_bq;
  link_s                                    lq;
  link_s                                    next_lq;
  sai_pkg::sample_t [sai_pkg::NUM_CH-1:0]   frame_bank;
  logic                                     frame_pulse;
  logic                                     sample_clk;
  logic [3:0]                               cfg_link;
  logic                                     wcp;
  logic [2:0]                               fmt;
  logic                                     is_tdm;
  sai_pkg::sample_t [sai_pkg::NUM_PINS-1:0] shifted;
  logic                                     lr_edge;
  logic                                     start;
  logic [sai_pkg::BIT_CNT_W-1:0]            cnt_now;
  logic                                     side;
  logic                                     prev_side;
  logic                                     cap_stereo;
  logic                                     cap_tdm;
  logic [2:0]                               cap_slot;
  logic                                     done;

  frame_if flink ();

  // ---------------- register side ----------------

  function automatic logic [31:0] reg_read(
    input logic [sai_pkg::ADDR_W-1:0]               addr,
    input bus_s                                     b,
    input sai_pkg::sample_t [sai_pkg::NUM_CH-1:0]   bk
  );
    logic [31:0] r;
    logic [5:0]  off;
    r   = '0;
    off = addr - sai_pkg::ADDR_CHAN0;
    if (addr == sai_pkg::ADDR_CTRL) begin
      r[sai_pkg::CTRL_W-1:0] = b.ctrl;
    end else if (addr == sai_pkg::ADDR_STATUS) begin
      r[sai_pkg::STATUS_RSVD_BIT] =
        sai_pkg::fmt_reserved(b.ctrl[sai_pkg::CTRL_FMT_LSB +: sai_pkg::CTRL_FMT_W]);
      r[sai_pkg::STATUS_SYNC_BIT] = b.synced;
      r[sai_pkg::STATUS_CNT_LSB +: sai_pkg::FRAME_CNT_W] = b.frame_cnt;
    end else if (addr >= sai_pkg::ADDR_CHAN0 && addr <= sai_pkg::ADDR_CHAN_END
                 && addr[1:0] == 2'h0) begin
      r[sai_pkg::SAMPLE_W-1:0] = bk[off[4:2]];
    end
    return r;
  endfunction

  always_comb begin
    next_bq = bq;
    if (frame_pulse) begin
      next_bq.frame_cnt = bq.frame_cnt + 16'h0001;
      next_bq.synced    = 1'b1;
    end
    if (!bq.waitrequest) begin
      // answer cycle: the write lands here, then the slave goes busy again
      next_bq.waitrequest = 1'b1;
      if (write && address == sai_pkg::ADDR_CTRL && byteenable[0]) begin
        next_bq.ctrl = writedata[sai_pkg::CTRL_W-1:0] & sai_pkg::CTRL_WMASK; // [R7]
      end
    end else if (read || write) begin
      next_bq.waitrequest = 1'b0;
      next_bq.readdata    = read ? reg_read(address, bq, frame_bank) : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bq             <= '0;
      bq.ctrl        <= sai_pkg::CTRL_RESET;
      bq.waitrequest <= 1'b1;
    end else begin
      bq <= next_bq;
    end
  end

  assign readdata    = bq.readdata;
  assign waitrequest = bq.waitrequest;

  chk_ctrl_write_all: assert property ( // [R7]
    @(posedge clk) disable iff (!rst_n)
    (!waitrequest && write && address == sai_pkg::ADDR_CTRL && byteenable[0])
    |=> bq.ctrl[4:0] == $past(writedata[4:0]))
    else $error("control write did not take all polarity and format bits together");

  chk_bus_answer: assert property (
    @(posedge clk) disable iff (!rst_n)
    (waitrequest && (read || write)) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not given in one cycle");

  chk_answer_one_cycle: assert property (
    @(posedge clk) disable iff (!rst_n)
    !waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  chk_write_reads_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (waitrequest && write && !read) |=> readdata == 32'h0000_0000)
    else $error("write answer carried nonzero read data");

  // control only moves on an answered write to its own address
  chk_ctrl_hold_idle: assert property ( // [R7]
    @(posedge clk) disable iff (!rst_n)
    !(!waitrequest && write && address == sai_pkg::ADDR_CTRL && byteenable[0])
    |=> $stable(bq.ctrl))
    else $error("control changed without an answered write");

  chk_frame_count_step: assert property (
    @(posedge clk) disable iff (!rst_n)
    frame_pulse |=> bq.frame_cnt == $past(bq.frame_cnt) + 16'h0001 && bq.synced)
    else $error("frame counter did not step on a collected frame");

  chk_sync_sticky: assert property (
    @(posedge clk) disable iff (!rst_n)
    bq.synced |=> bq.synced)
    else $error("frame seen flag dropped");

  // ---------------- link side ----------------

  // bit clock polarity picks the sampling edge; change it only while the link is idle
  assign sample_clk = bit_clock ^ bq.ctrl[sai_pkg::CTRL_BCP_BIT]; // [R6]

  bit_sync #(
    .W (4)
  ) u_cfg_sync (
    .clk   (sample_clk),
    .rst_n (rst_n),
    .d     ({bq.ctrl[sai_pkg::CTRL_WCP_BIT],
             bq.ctrl[sai_pkg::CTRL_FMT_LSB +: sai_pkg::CTRL_FMT_W]}),
    .q     (cfg_link)
  );

  assign wcp    = cfg_link[3];
  assign fmt    = cfg_link[2:0];
  assign is_tdm = (fmt == sai_pkg::FMT_TDM);

  always_comb begin
    next_lq    = lq;
    cap_stereo = 1'b0;
    cap_tdm    = 1'b0;
    done       = 1'b0;
    for (int p = 0; p < int'(sai_pkg::NUM_PINS); p++) begin
      shifted[p] = {lq.shreg[p][sai_pkg::SAMPLE_W-2:0], serial_data_inputs[p]};
    end
    lr_edge = word_clock != lq.lr_prev;
    // TDM and pulse clocks start only on the edge named by the polarity bit
    start   = lr_edge && (!is_tdm || word_clock == wcp); // [R3] [R4] [R5]
    if (start) begin
      cnt_now = '0;
    end else if (!is_tdm && lq.bit_cnt == 8'hFF) begin
      cnt_now = lq.bit_cnt;
    end else begin
      cnt_now = lq.bit_cnt + 8'h01;
    end
    side      = (word_clock != wcp); // [R1] [R2] [R8]
    prev_side = (lq.lr_prev != wcp);
    cap_slot  = cnt_now[sai_pkg::BIT_CNT_W-1:sai_pkg::SLOT_LSB];
    next_lq.lr_prev = word_clock;
    next_lq.shreg   = shifted;
    next_lq.bit_cnt = cnt_now;
    if (start) begin
      next_lq.framed = 1'b1;
    end
    unique case (fmt)
      sai_pkg::FMT_I2S, sai_pkg::FMT_LEFT: begin
        // I2S has its MSB one bit late, left-justified has it at slot start
        if (lq.framed && cnt_now == ((fmt == sai_pkg::FMT_I2S) ?
            sai_pkg::I2S_LAST_BIT : sai_pkg::LEFT_LAST_BIT)) begin
          cap_stereo = 1'b1;
          done       = side;
          for (int p = 0; p < int'(sai_pkg::NUM_PINS); p++) begin
            next_lq.bank[{2'(p), side}] = shifted[p]; // [R1] [R2] [R8]
          end
        end
      end
      sai_pkg::FMT_RIGHT: begin
        // right-justified words end at the slot edge: keep the last bits seen
        if (lq.framed && lr_edge) begin
          cap_stereo = 1'b1;
          done       = prev_side;
          for (int p = 0; p < int'(sai_pkg::NUM_PINS); p++) begin
            next_lq.bank[{2'(p), prev_side}] = lq.shreg[p]; // [R8]
          end
        end
      end
      sai_pkg::FMT_TDM: begin
        // whole stream on the first input, MSB one bit after each slot start
        if (lq.framed && cnt_now[sai_pkg::SLOT_LSB-1:0] == sai_pkg::TDM_LAST_BIT) begin
          cap_tdm = 1'b1;
          done    = (cap_slot == sai_pkg::TDM_LAST_SLOT);
          next_lq.bank[cap_slot] = shifted[0]; // [R9] [R10] [R11] [R12]
        end
      end
      default: begin
        // reserved format codes capture nothing
      end
    endcase
    if (done) begin
      next_lq.hold   = next_lq.bank;
      next_lq.toggle = ~lq.toggle;
    end
  end

  always_ff @(posedge sample_clk or negedge rst_n) begin
    if (!rst_n) begin
      lq <= '0;
    end else begin
      lq <= next_lq;
    end
  end

  assign flink.bank   = lq.hold;
  assign flink.toggle = lq.toggle;

  frame_collect u_collect (
    .clk         (clk),
    .rst_n       (rst_n),
    .link        (flink),
    .bank        (frame_bank),
    .frame_pulse (frame_pulse)
  );

  chk_left_on_low: assert property ( // [R1]
    @(posedge sample_clk) disable iff (!rst_n)
    (cap_stereo && fmt != sai_pkg::FMT_RIGHT && !wcp && !word_clock)
    |=> lq.bank[0] == $past(shifted[0]))
    else $error("low word clock not taken as left with polarity 0");

  chk_left_on_high: assert property ( // [R2]
    @(posedge sample_clk) disable iff (!rst_n)
    (cap_stereo && fmt == sai_pkg::FMT_I2S && wcp && word_clock)
    |=> lq.bank[0] == $past(shifted[0]))
    else $error("channels not swapped with polarity 1");

  chk_stereo_restart: assert property (
    @(posedge sample_clk) disable iff (!rst_n)
    (!is_tdm && lr_edge) |=> lq.bit_cnt == 8'h00)
    else $error("stereo slot count not restarted on word clock edge");

  chk_tdm_start_fall: assert property ( // [R3]
    @(posedge sample_clk) disable iff (!rst_n)
    (is_tdm && !wcp && lq.lr_prev && !word_clock) |=> lq.bit_cnt == 8'h00)
    else $error("TDM frame did not start after falling word clock");

  chk_tdm_start_rise: assert property ( // [R4]
    @(posedge sample_clk) disable iff (!rst_n)
    (is_tdm && wcp && !lq.lr_prev && word_clock) |=> lq.bit_cnt == 8'h00)
    else $error("TDM frame did not start after rising word clock");

  chk_pulse_one_start: assert property ( // [R5]
    @(posedge sample_clk) disable iff (!rst_n)
    (is_tdm && !wcp && lq.lr_prev && !word_clock) ##1 (is_tdm && word_clock)
    |=> lq.bit_cnt == 8'h01)
    else $error("trailing edge of word clock pulse restarted the frame");

  chk_pulse_high_start: assert property ( // [R5]
    @(posedge sample_clk) disable iff (!rst_n)
    (is_tdm && wcp && !lq.lr_prev && word_clock) ##1 (is_tdm && !word_clock)
    |=> lq.bit_cnt == 8'h01)
    else $error("trailing edge of high word clock pulse restarted the frame");

  chk_justified_high: assert property ( // [R8]
    @(posedge sample_clk) disable iff (!rst_n)
    (cap_stereo && fmt == sai_pkg::FMT_LEFT && wcp && word_clock)
    |=> lq.bank[0] == $past(shifted[0]))
    else $error("high word clock not taken as left in justified format");

  // right-justified left word ends when the word clock leaves the left level
  chk_right_last_bits: assert property ( // [R8]
    @(posedge sample_clk) disable iff (!rst_n)
    (lq.framed && fmt == sai_pkg::FMT_RIGHT && lr_edge && lq.lr_prev == wcp)
    |=> lq.bank[0] == $past(lq.shreg[0]))
    else $error("right-justified left word not kept at slot edge");

  chk_tdm_msb_delay: assert property ( // [R10]
    @(posedge sample_clk) disable iff (!rst_n)
    (cap_tdm && $past(start, 24) && $past(is_tdm, 24))
    |-> shifted[0][sai_pkg::SAMPLE_W-1] == $past(serial_data_inputs[0], 23))
    else $error("TDM MSB not taken one bit after slot start");

  chk_tdm_half: assert property ( // [R11]
    @(posedge sample_clk) disable iff (!rst_n)
    (cap_tdm && cnt_now < sai_pkg::TDM_HALF_BIT)
    |=> lq.bank[3'($past(cnt_now) / 8'h20)] == $past(shifted[0]))
    else $error("TDM channel placed in the wrong half of the frame");

  chk_tdm_second_half: assert property ( // [R11]
    @(posedge sample_clk) disable iff (!rst_n)
    (cap_tdm && cnt_now >= sai_pkg::TDM_HALF_BIT)
    |=> lq.bank[3'($past(cnt_now) / 8'h20)] == $past(shifted[0]))
    else $error("TDM upper channel placed in the wrong half of the frame");

  // a finished frame is frozen for the system side and flagged once
  chk_done_handover: assert property (
    @(posedge sample_clk) disable iff (!rst_n)
    done |=> lq.toggle != $past(lq.toggle) && lq.hold == lq.bank)
    else $error("finished frame not handed over");

  chk_reserved_idle: assert property ( // [R13]
    @(posedge sample_clk) disable iff (!rst_n)
    sai_pkg::fmt_reserved(fmt) |=> $stable(lq.bank) && $stable(lq.toggle))
    else $error("reserved format code captured data");
endmodule // serial_audio_rx

// ---- verif/audio_source.sv ----
`timescale 1ns/100ps
module audio_source (
  // link pins driven by the source
  output logic       bit_clock,
  output logic       word_clock,
  output logic [3:0] serial_data_inputs
);
  // two bit clock edges during reset, then still until a frame
  initial begin
    bit_clock          = 1'b1;
    word_clock         = 1'b1;
    serial_data_inputs = 4'h0;
    #12 bit_clock = 1'b0;
    #24 bit_clock = 1'b1;
  end

  // one frame with three lead bits and one trailing bit
  task automatic frame(input logic [2:0] fmt, input logic bcp, input logic wcp,
                       input sai_pkg::sample_t s [8]);
    int         x;
    int         j;
    int         q;
    int         c;
    logic       sd;
    logic [3:0] d;
    for (x = -3; x < ((fmt == sai_pkg::FMT_TDM) ? 257 : 65); x++) begin
      bit_clock = bcp;
      d = ~serial_data_inputs; // undriven bits toggle
      j = (x < 0) ? 0 : x % 32;
      q = (fmt == sai_pkg::FMT_LEFT) ? 23 - j : (fmt == sai_pkg::FMT_RIGHT) ? 31 - j : 24 - j;
      if (x < 0 || q < 0 || q > 23) q = -1;
      if (fmt == sai_pkg::FMT_TDM) begin
        word_clock = (x == 0) ? wcp : ~wcp;
        if (x < 256 && q >= 0) d[0] = s[x / 32][q];
      end else begin
        sd = (x < 0) || (x >= 32 && x < 64);
        word_clock = sd ? ~wcp : wcp;
        for (c = 0; c < 4; c++) begin
          if (x < 64 && q >= 0) d[c] = s[2 * c + int'(sd)][q];
        end
      end
      serial_data_inputs = d;
      #24 bit_clock = ~bcp;
      #24;
    end
  endtask
endmodule // audio_source

// ---- verif/serial_audio_rx_tb.sv ----
`timescale 1ns/100ps
module serial_audio_rx_tb;
  logic             clk;
  logic             rst_n;
  logic             read;
  logic             write;
  logic             waitrequest;
  logic             bit_clock;
  logic             word_clock;
  logic [5:0]       address;
  logic [31:0]      writedata;
  logic [31:0]      readdata;
  logic [31:0]      rd;
  logic [3:0]       byteenable;
  logic [3:0]       serial_data_inputs;
  int               failures;
  int               checked;
  int               f;
  int               m;
  sai_pkg::sample_t smp [8];

  serial_audio_rx DUT (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .bit_clock(bit_clock), .word_clock(word_clock),
    .serial_data_inputs(serial_data_inputs)
  );
  audio_source src (
    .bit_clock(bit_clock), .word_clock(word_clock), .serial_data_inputs(serial_data_inputs)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus access, held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                     input logic [3:0] be);
    int n;
    @(posedge clk);
    address    <= a;
    writedata  <= wd;
    byteenable <= be;
    read       <= ~wr;
    write      <= wr;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n == 50) begin
      failures++;
      final_report;
    end
  endtask

  task automatic t_regs;
    acc(1'b0, sai_pkg::ADDR_CTRL, 32'h0, 4'hF);
    chk(rd, 32'h0000_0000); // control reset value
    acc(1'b1, sai_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 4'hE);
    acc(1'b0, sai_pkg::ADDR_CTRL, 32'h0, 4'hF);
    chk(rd, 32'h0000_0000); // byte 0 not enabled
    acc(1'b1, sai_pkg::ADDR_CTRL, 32'h0000_00FF, 4'hF);
    acc(1'b0, sai_pkg::ADDR_CTRL, 32'h0, 4'hF);
    chk(rd, 32'h0000_001F); // upper bits read 0
    acc(1'b1, 6'h3C, 32'hFFFF_FFFF, 4'hF);
    acc(1'b0, 6'h3C, 32'h0, 4'hF);
    chk(rd, 32'h0000_0000); // unmapped
    acc(1'b1, sai_pkg::ADDR_CTRL, 32'h0000_0005, 4'hF);
    acc(1'b0, sai_pkg::ADDR_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h0000_0001);
  endtask

  // configure, send one frame, then compare the channel registers, or check that the frame count held when fmt and mfmt differ
  task automatic t_frame(input logic [2:0] fmt, input logic bcp, input logic wcp,
                         input logic [2:0] mfmt);
    int          c;
    int          n;
    logic [15:0] cnt;
    for (c = 0; c < 8; c++) smp[c] = 24'(c * 24'h13579B) ^ {fmt, bcp, wcp, 19'h2AD51};
    acc(1'b1, sai_pkg::ADDR_CTRL, {24'h0, 3'h0, wcp, bcp, fmt}, 4'hF);
    acc(1'b0, sai_pkg::ADDR_STATUS, 32'h0, 4'hF);
    cnt = rd[31:16];
    src.frame(mfmt, bcp, wcp, smp);
    if (fmt != mfmt) begin
      repeat (10) acc(1'b0, sai_pkg::ADDR_STATUS, 32'h0, 4'hF);
      chk({16'h0, rd[31:16]}, {16'h0, cnt});
    end else begin
      for (n = 0; n < 20; n++) begin
        acc(1'b0, sai_pkg::ADDR_CHAN0 + 6'h1C, 32'h0, 4'hF);
        if (rd === {8'h0, smp[7]}) break;
      end
      for (c = 0; c < 8; c++) begin
        acc(1'b0, sai_pkg::ADDR_CHAN0 + 6'(4 * c), 32'h0, 4'hF);
        chk(rd, {8'h0, smp[c]});
      end
      if (fmt == sai_pkg::FMT_TDM) begin
        acc(1'b0, sai_pkg::ADDR_STATUS, 32'h0, 4'hF);
        chk(rd, {cnt + 16'h1, 16'h0002});
      end
    end
  endtask

  initial begin
    failures   = 0;
    checked    = 0;
    rst_n      = 1'b0;
    read       = 1'b0;
    write      = 1'b0;
    address    = 6'h00;
    writedata  = 32'h0;
    byteenable = 4'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    for (f = 0; f < 4; f++) begin
      for (m = 0; m < 4; m++) begin
        t_frame(3'(f), m[0], m[1], 3'(f));
      end
    end
    t_frame(3'h5, 1'b0, 1'b0, sai_pkg::FMT_TDM);
    final_report;
  end
endmodule // serial_audio_rx_tb
